// ===== hw/port_a_pin_function_select.sv
/*
  Port A pin function controller: direction and two function select
  registers on a classic Wishbone slave, and the sixteen pin muxes.
  Assumes peripherals and bus controller run on clk_i; pads are
  asynchronous and are synchronised here.
*/
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
// How it works
// R01 - Direction register, 16 bits: 1 drives the pin, 0 makes it input.
// R02 - Direction counts only for plain port and timer capture functions.
// R03 - Direction register clears to zero on power-on reset only.
// R04 - Function registers reset to 3302 and ff95 on power-on only.
// R05 - Upper register serves pins 15 to 8, lower pins 7 to 0.
// R06 - Pin 15: port, interrupt 3, reserved, DMA request 1.
// R07 - Pin 14: port, interrupt 2, reserved, DMA acknowledge 1.
// R08 - Pin 13: port, interrupt 1, timer clock B, DMA request 0.
// R09 - Pin 12: port, interrupt 0, timer clock A, DMA acknowledge 0.
// R10 - Pin 11: port, upper parity, timer 1 capture B, reserved.
// R11 - Pin 10: port, lower parity, timer 1 capture A, reserved.
// R12 - Pin 9: port, address hold, converter trigger, interrupt out.
// R13 - Reserved bits read one; software writes them as one.
// R14 - Pin 8: port or bus request input.
// R15 - Pin 7: port or bus acknowledge output, reset one.
// R16 - Pin 6: port or read strobe output, reset one.
// R17 - Pin 5: port or upper write or byte strobe, reset one.
// R18 - Pin 4: port or lower write strobe output, reset one.
// R19 - Pin 3: port, chip select 7, wait input, reserved.
// R20 - Pins 2 and 0: port, chip select, timer 0 capture, reserved.
// R21 - Mux takes selected output and enable; input goes to both paths.
// R22 - Pin 1: port, chip select 5, row strobe, reserved.
`timescale 1ns/1ps
module port_a_pin_function_select
  import pinmux_pkg::*;
#(
  parameter int NPIN = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [NPIN-1:0]   pin_i,
  output logic      [NPIN-1:0]   pin_o,
  output logic      [NPIN-1:0]   pin_oe_n_o,
  input  wire logic [NPIN-1:0]   port_out_i,
  input  wire periph_out_s       from_periph_i,
  output periph_in_s             to_periph_o,
  output logic      [NPIN-1:0]   port_data_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  pinmux_state_s         s_q;
  pinmux_state_s         s_d;
  logic [NPIN-1:0]       pin_sync;
  logic [NPIN-1:0][1:0]  fn;
  logic [NPIN-1:0][3:0]  alt_out;
  logic [NPIN-1:0][3:0]  alt_drv;
  logic [NPIN-1:0][3:0]  dir_mask;
  logic                  req;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0]  sel,
                                        input logic [15:0] rsv);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    // Reserved bits are held at one whatever is written.
    merge = r | rsv; // [R13]
  endfunction

  pin_sync #(
    .W (NPIN)
  ) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (pin_i),
    .sync_o (pin_sync)
  );

  // ****************************************************************
  // Function codes per pin
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      fn[i + 8] = s_q.upper[2*i +: 2]; // [R05]
      fn[i]     = s_q.lower[2*i +: 2]; // [R05]
    end
    fn[8] = {1'b0, s_q.upper[PIN8_BIT]}; // [R14]
    fn[7] = {1'b0, s_q.lower[PIN7_BIT]}; // [R15]
    fn[6] = {1'b0, s_q.lower[PIN6_BIT]}; // [R16]
    fn[5] = {1'b0, s_q.lower[PIN5_BIT]}; // [R17]
    fn[4] = {1'b0, s_q.lower[PIN4_BIT]}; // [R18]
  end

  // ****************************************************************
  // Candidate outputs per pin and code
  // ****************************************************************
  always_comb begin
    alt_out  = '0;
    alt_drv  = '0;
    dir_mask = '0;
    for (int i = 0; i < NPIN; i++) begin
      alt_out[i][FN_PORT]  = port_out_i[i];
      dir_mask[i][FN_PORT] = 1'b1; // [R02]
    end
    alt_out[14][FN_THREE] = from_periph_i.dma_acknowledge_ch1; // [R07]
    alt_drv[14][FN_THREE] = 1'b1; // [R07]
    alt_out[12][FN_THREE] = from_periph_i.dma_acknowledge_ch0; // [R09]
    alt_drv[12][FN_THREE] = 1'b1; // [R09]
    alt_out[11][FN_ONE]   = from_periph_i.upper_data_parity; // [R10]
    alt_drv[11][FN_ONE]   = from_periph_i.upper_data_parity_oe;
    alt_out[11][FN_TWO]   = from_periph_i.timer1_capcomp_b; // [R10]
    dir_mask[11][FN_TWO]  = 1'b1; // [R02]
    alt_out[10][FN_ONE]   = from_periph_i.lower_data_parity; // [R11]
    alt_drv[10][FN_ONE]   = from_periph_i.lower_data_parity_oe;
    alt_out[10][FN_TWO]   = from_periph_i.timer1_capcomp_a; // [R11]
    dir_mask[10][FN_TWO]  = 1'b1; // [R02]
    alt_out[9][FN_ONE]    = from_periph_i.address_hold_strobe; // [R12]
    alt_drv[9][FN_ONE]    = 1'b1;
    alt_out[9][FN_THREE]  = from_periph_i.interrupt_request_out; // [R12]
    alt_drv[9][FN_THREE]  = 1'b1;
    alt_out[7][FN_ONE]    = from_periph_i.bus_acknowledge; // [R15]
    alt_drv[7][FN_ONE]    = 1'b1;
    alt_out[6][FN_ONE]    = from_periph_i.read_strobe_n; // [R16]
    alt_drv[6][FN_ONE]    = 1'b1;
    alt_out[5][FN_ONE]    = from_periph_i.upper_write_strobe_n; // [R17]
    alt_drv[5][FN_ONE]    = 1'b1;
    alt_out[4][FN_ONE]    = from_periph_i.lower_write_strobe_n; // [R18]
    alt_drv[4][FN_ONE]    = 1'b1;
    alt_out[3][FN_ONE]    = from_periph_i.chip_select_7_n; // [R19]
    alt_drv[3][FN_ONE]    = 1'b1;
    alt_out[2][FN_ONE]    = from_periph_i.chip_select_6_n; // [R20]
    alt_drv[2][FN_ONE]    = 1'b1;
    alt_out[2][FN_TWO]    = from_periph_i.timer0_capcomp_b; // [R20]
    dir_mask[2][FN_TWO]   = 1'b1; // [R02]
    alt_out[1][FN_ONE]    = from_periph_i.chip_select_5_n; // [R22]
    alt_drv[1][FN_ONE]    = 1'b1;
    alt_out[1][FN_TWO]    = from_periph_i.row_address_strobe; // [R22]
    alt_drv[1][FN_TWO]    = 1'b1;
    alt_out[0][FN_ONE]    = from_periph_i.chip_select_4_n; // [R20]
    alt_drv[0][FN_ONE]    = 1'b1;
    alt_out[0][FN_TWO]    = from_periph_i.timer0_capcomp_a; // [R20]
    dir_mask[0][FN_TWO]   = 1'b1; // [R02]
  end

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    pin_cell u_cell (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .sel_i      (fn[g]),
      .dir_i      (s_q.dir[g]),
      .alt_out_i  (alt_out[g]),
      .alt_drv_i  (alt_drv[g]),
      .dir_mask_i (dir_mask[g]),
      .pin_o      (pin_o[g]),
      .pin_oe_n_o (pin_oe_n_o[g])
    );
  end

  // ****************************************************************
  // Register bus and input delivery
  // ****************************************************************
  assign req = wb_cyc_i && wb_stb_i && !s_q.ack;

  always_comb begin
    s_d     = s_q;
    s_d.ack = req;
    if (req) begin
      // Unmapped addresses are acknowledged and read as zero.
      case (wb_adr_i)
        OFS_DIR:   s_d.rdat = s_q.dir;
        OFS_UPPER: s_d.rdat = s_q.upper | UPPER_RSV; // [R13]
        OFS_LOWER: s_d.rdat = s_q.lower | LOWER_RSV; // [R13]
        default:   s_d.rdat = 16'h0000;
      endcase
      if (wb_we_i) begin
        case (wb_adr_i)
          OFS_DIR: begin
            s_d.dir = merge(s_q.dir, wb_dat_i[15:0],
                            wb_sel_i[1:0], 16'h0000); // [R01]
          end
          OFS_UPPER: begin
            s_d.upper = merge(s_q.upper, wb_dat_i[15:0],
                              wb_sel_i[1:0], UPPER_RSV); // [R05]
          end
          OFS_LOWER: begin
            s_d.lower = merge(s_q.lower, wb_dat_i[15:0],
                              wb_sel_i[1:0], LOWER_RSV); // [R05]
          end
          default: begin
            s_d.dir = s_q.dir;
          end
        endcase
      end
    end
    // The port read path sees every pin, whatever its function.
    s_d.port_data = pin_sync; // [R21]
    s_d.to_periph = '0;
    s_d.to_periph.ext_interrupt_3 =
      (fn[15] == FN_ONE) && pin_sync[15]; // [R06]
    s_d.to_periph.dma_request_ch1 =
      (fn[15] == FN_THREE) && pin_sync[15]; // [R06]
    s_d.to_periph.ext_interrupt_2 =
      (fn[14] == FN_ONE) && pin_sync[14]; // [R07]
    s_d.to_periph.ext_interrupt_1 =
      (fn[13] == FN_ONE) && pin_sync[13]; // [R08]
    s_d.to_periph.timer_ext_clock_b =
      (fn[13] == FN_TWO) && pin_sync[13]; // [R08]
    s_d.to_periph.dma_request_ch0 =
      (fn[13] == FN_THREE) && pin_sync[13]; // [R08]
    s_d.to_periph.ext_interrupt_0 =
      (fn[12] == FN_ONE) && pin_sync[12]; // [R09]
    s_d.to_periph.timer_ext_clock_a =
      (fn[12] == FN_TWO) && pin_sync[12]; // [R09]
    s_d.to_periph.upper_data_parity =
      (fn[11] == FN_ONE) && pin_sync[11]; // [R10]
    s_d.to_periph.timer1_capcomp_b =
      (fn[11] == FN_TWO) && pin_sync[11]; // [R10]
    s_d.to_periph.lower_data_parity =
      (fn[10] == FN_ONE) && pin_sync[10]; // [R11]
    s_d.to_periph.timer1_capcomp_a =
      (fn[10] == FN_TWO) && pin_sync[10]; // [R11]
    s_d.to_periph.converter_start_trigger =
      (fn[9] == FN_TWO) && pin_sync[9]; // [R12]
    s_d.to_periph.bus_request_in =
      (fn[8] == FN_ONE) && pin_sync[8]; // [R14]
    s_d.to_periph.wait_in =
      (fn[3] == FN_TWO) && pin_sync[3]; // [R19]
    s_d.to_periph.timer0_capcomp_b =
      (fn[2] == FN_TWO) && pin_sync[2]; // [R20]
    s_d.to_periph.timer0_capcomp_a =
      (fn[0] == FN_TWO) && pin_sync[0]; // [R20]
    // Only the power-on reset reaches these registers; other reset
    // sources of the chip must not drive rst_i.
    if (rst_i) begin
      s_d       = '0;
      s_d.dir   = DIR_RST; // [R03]
      s_d.upper = UPPER_RST; // [R04]
      s_d.lower = LOWER_RST; // [R04]
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign wb_ack_o    = s_q.ack;
  assign wb_dat_o    = {16'h0000, s_q.rdat};
  assign to_periph_o = s_q.to_periph;
  assign port_data_o = s_q.port_data;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_dir_reset: assert property ( // [R03]
    @(posedge clk_i) rst_i |=> (s_q.dir == DIR_RST))
    else $error("direction register not cleared by reset");

  a_func_reset: assert property ( // [R04]
    @(posedge clk_i) rst_i |=>
      (s_q.upper == UPPER_RST) && (s_q.lower == LOWER_RST))
    else $error("function registers wrong after reset");

  a_rsv_ones: assert property ( // [R13]
    @(posedge clk_i) disable iff (rst_i)
    ((s_q.upper & UPPER_RSV) == UPPER_RSV) &&
    ((s_q.lower & LOWER_RSV) == LOWER_RSV))
    else $error("reserved bit not held at one");

  a_dir_write: assert property ( // [R01]
    @(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == OFS_DIR && wb_sel_i[1:0] == 2'h3)
      |=> (s_q.dir == $past(wb_dat_i[15:0])) && wb_ack_o)
    else $error("direction write not stored");

  a_dir_ignored: assert property ( // [R02]
    @(posedge clk_i) disable iff (rst_i)
    (fn[15] == FN_ONE) |=> pin_oe_n_o[15])
    else $error("input function pin drives");

  a_dir_used: assert property ( // [R02]
    @(posedge clk_i) disable iff (rst_i)
    (fn[11] == FN_TWO) |=> (pin_oe_n_o[11] == !$past(s_q.dir[11])))
    else $error("capture pin ignores direction");

  a_dreq_route: assert property ( // [R06]
    @(posedge clk_i) disable iff (rst_i)
    (fn[15] == FN_THREE) |=>
      (to_periph_o.dma_request_ch1 == $past(pin_sync[15])) &&
      !to_periph_o.ext_interrupt_3)
    else $error("DMA request input misrouted");

  a_read_strobe: assert property ( // [R16]
    @(posedge clk_i) disable iff (rst_i)
    s_q.lower[PIN6_BIT] |=>
      !pin_oe_n_o[6] && (pin_o[6] == $past(from_periph_i.read_strobe_n)))
    else $error("read strobe not on pin 6");

  a_irq_out: assert property ( // [R12]
    @(posedge clk_i) disable iff (rst_i)
    (fn[9] == FN_THREE) |=> !pin_oe_n_o[9] &&
      (pin_o[9] == $past(from_periph_i.interrupt_request_out)))
    else $error("interrupt output not on pin 9");

  a_port_read: assert property ( // [R21]
    @(posedge clk_i) disable iff (rst_i)
    ##1 (port_data_o == $past(pin_sync)))
    else $error("port read path stale");

  a_ack_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_wait_route: assert property ( // [R19]
    @(posedge clk_i) disable iff (rst_i)
    (fn[3] == FN_TWO) |=> (to_periph_o.wait_in == $past(pin_sync[3])))
    else $error("wait input misrouted");

  a_parity_drive: assert property ( // [R11]
    @(posedge clk_i) disable iff (rst_i)
    (fn[10] == FN_ONE) |=>
      (pin_oe_n_o[10] == !$past(from_periph_i.lower_data_parity_oe)))
    else $error("parity pin drive wrong");

  a_rsv_code_idle: assert property ( // [R20]
    @(posedge clk_i) disable iff (rst_i)
    (fn[2] == FN_THREE) |=> pin_oe_n_o[2])
    else $error("reserved code drives pin 2");

  a_row_strobe: assert property ( // [R22]
    @(posedge clk_i) disable iff (rst_i)
    (fn[1] == FN_TWO) |=> !pin_oe_n_o[1] &&
      (pin_o[1] == $past(from_periph_i.row_address_strobe)))
    else $error("row strobe not on pin 1");

endmodule

// ===== hw/pinmux_pkg.sv
/*
  Shared constants, register map and carrier structs of the port A
  pin function controller.
  Assumes a single 10 MHz system clock and a synchronous reset.
*/
package pinmux_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADR_W     = 4;
  localparam logic [3:0]  OFS_DIR   = 4'h0;
  localparam logic [3:0]  OFS_UPPER = 4'h4;
  localparam logic [3:0]  OFS_LOWER = 4'h8;
  localparam logic [15:0] DIR_RST   = 16'h0000;
  localparam logic [15:0] UPPER_RST = 16'h3302;
  localparam logic [15:0] LOWER_RST = 16'hff95;
  localparam logic [15:0] UPPER_RSV = 16'h0002;
  localparam logic [15:0] LOWER_RSV = 16'haa00;

  // ****************************************************************
  // Field positions and function codes
  // ****************************************************************
  localparam int PIN8_BIT = 0;
  localparam int PIN7_BIT = 14;
  localparam int PIN6_BIT = 12;
  localparam int PIN5_BIT = 10;
  localparam int PIN4_BIT = 8;
  localparam logic [1:0] FN_PORT = 2'h0;
  localparam logic [1:0] FN_ONE  = 2'h1;
  localparam logic [1:0] FN_TWO  = 2'h2;
  localparam logic [1:0] FN_THREE = 2'h3;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic dma_acknowledge_ch1;
    logic dma_acknowledge_ch0;
    logic upper_data_parity;
    logic upper_data_parity_oe;
    logic lower_data_parity;
    logic lower_data_parity_oe;
    logic timer1_capcomp_a;
    logic timer1_capcomp_b;
    logic timer0_capcomp_a;
    logic timer0_capcomp_b;
    logic address_hold_strobe;
    logic interrupt_request_out;
    logic bus_acknowledge;
    logic read_strobe_n;
    logic upper_write_strobe_n;
    logic lower_write_strobe_n;
    logic chip_select_7_n;
    logic chip_select_6_n;
    logic chip_select_5_n;
    logic chip_select_4_n;
    logic row_address_strobe;
  } periph_out_s;

  typedef struct packed {
    logic ext_interrupt_3;
    logic ext_interrupt_2;
    logic ext_interrupt_1;
    logic ext_interrupt_0;
    logic dma_request_ch1;
    logic dma_request_ch0;
    logic timer_ext_clock_a;
    logic timer_ext_clock_b;
    logic timer1_capcomp_a;
    logic timer1_capcomp_b;
    logic timer0_capcomp_a;
    logic timer0_capcomp_b;
    logic upper_data_parity;
    logic lower_data_parity;
    logic converter_start_trigger;
    logic bus_request_in;
    logic wait_in;
  } periph_in_s;

  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] upper;
    logic [15:0] lower;
    logic        ack;
    logic [15:0] rdat;
    logic [15:0] port_data;
    periph_in_s  to_periph;
  } pinmux_state_s;

  typedef struct packed {
    logic out;
    logic oe_n;
  } cell_state_s;

endpackage

// ===== hw/pin_sync.sv
/*
  Two-stage synchroniser for a vector of pin levels.
  Assumes the pins are asynchronous to clk_i.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_s;

  sync_state_s s_q;
  sync_state_s s_d;

  // The first stage feeds only the second stage.
  always_comb begin
    s_d.meta = pin_i;
    s_d.sync = s_q.meta;
    if (rst_i) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign sync_o = s_q.sync;
endmodule

// ===== hw/pin_cell.sv
/*
  One pin of the multiplexer: picks value and drive of the chosen
  function and registers them toward the pad.
  Assumes selection and candidates are on the clk_i domain.
*/
`timescale 1ns/1ps
module pin_cell
  import pinmux_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       dir_i,
  input  wire logic [3:0] alt_out_i,
  input  wire logic [3:0] alt_drv_i,
  input  wire logic [3:0] dir_mask_i,
  output logic            pin_o,
  output logic            pin_oe_n_o
);
  cell_state_s s_q;
  cell_state_s s_d;

  always_comb begin
    s_d.out = alt_out_i[sel_i];
    // The direction bit counts only where the function allows it.
    if (dir_mask_i[sel_i]) begin
      s_d.oe_n = !dir_i; // [R02] [R01]
    end else begin
      s_d.oe_n = !alt_drv_i[sel_i]; // [R02] [R21]
    end
    if (rst_i) begin
      s_d.out  = 1'b0;
      s_d.oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign pin_o      = s_q.out;
  assign pin_oe_n_o = s_q.oe_n;
endmodule

// ===== bench/periph_model.sv
/*
  Behavioural model of the peripherals and the bus controller that share
  the port A pins. Every output value and drive request follows one level
  that the bench chooses.
  Assumes the bench moves the level just after a rising clock edge.
*/
`timescale 1ns/1ps
module periph_model
  import pinmux_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  lvl_i,
  output periph_out_s from_periph_o
);
  // ********************************************************************
  // Registered outputs
  // ********************************************************************
  // Registered like a real peripheral, so the mux sees the new level one
  // cycle late.
  always_ff @(posedge clk_i) begin
    from_periph_o <= {$bits(periph_out_s){lvl_i}};
  end
endmodule

// ===== bench/tb_top.sv
/*
  Self-checking bench of the port A pin function controller.
  Assumes the design package and the peripheral model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import pinmux_pkg::*;
  // ********************************************************************
  // Wiring
  // ********************************************************************
  logic             clk_i;
  logic             rst_i;
  logic             cyc;
  logic             we;
  logic [ADR_W-1:0] adr;
  logic [3:0]       sel;
  logic [31:0]      wdat;
  logic [31:0]      rdat;
  logic             ack;
  logic [15:0]      ext;
  logic [15:0]      pad;
  logic [15:0]      pin_o;
  logic [15:0]      oe_n;
  logic [15:0]      port_out;
  logic [15:0]      port_data;
  logic             lvl;
  periph_out_s      from_periph;
  periph_in_s       to_periph;
  int               fail_count;
  int               samples_checked;
  // Each entry: upper select, register value, pin, kind, peripheral input.
  // Kind 0 drives, 1 is an input, 2 is reserved, 3 is a parity line.
  localparam logic [47:0] TAB [38] = '{
    48'h1_4002_f_1_10000, 48'h1_8002_f_2_00000, 48'h1_c002_f_1_01000,
    48'h1_1002_e_1_08000, 48'h1_2002_e_2_00000, 48'h1_3002_e_0_00000,
    48'h1_0402_d_1_04000, 48'h1_0802_d_1_00200, 48'h1_0c02_d_1_00800,
    48'h1_0102_c_1_02000, 48'h1_0202_c_1_00400, 48'h1_0302_c_0_00000,
    48'h1_0042_b_3_00010, 48'h1_0082_b_0_00000, 48'h1_00c2_b_2_00000,
    48'h1_0012_a_3_00008, 48'h1_0022_a_0_00000, 48'h1_0032_a_2_00000,
    48'h1_0006_9_0_00000, 48'h1_000a_9_1_00004, 48'h1_000e_9_0_00000,
    48'h1_0003_8_1_00002, 48'h0_ea00_7_0_00000, 48'h0_ba00_6_0_00000,
    48'h0_ae00_5_0_00000, 48'h0_ab00_4_0_00000, 48'h0_aa40_3_0_00000,
    48'h0_aa80_3_1_00001, 48'h0_aac0_3_2_00000, 48'h0_aa10_2_0_00000,
    48'h0_aa20_2_0_00000, 48'h0_aa30_2_2_00000, 48'h0_aa04_1_0_00000,
    48'h0_aa08_1_0_00000, 48'h0_aa0c_1_2_00000, 48'h0_aa01_0_0_00000,
    48'h0_aa02_0_0_00000, 48'h0_aa03_0_2_00000};

  // The pad level is what the design drives, else what the board drives.
  assign pad = (oe_n & ext) | (~oe_n & pin_o);

  port_a_pin_function_select uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pad), .pin_o(pin_o),
    .pin_oe_n_o(oe_n), .port_out_i(port_out),
    .from_periph_i(from_periph), .to_periph_o(to_periph),
    .port_data_o(port_data));

  periph_model periph (
    .clk_i(clk_i), .lvl_i(lvl), .from_periph_o(from_periph));

  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; the answer is taken at the edge that shows ack.
  task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                    input logic [3:0] s, input logic [15:0] d,
                    output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t bus answer missing", $time);
      end_sim();
    end
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, 4'h3, d, q);
  endtask

  task automatic rd(input logic [ADR_W-1:0] a, input logic [15:0] e);
    logic [31:0] q;
    wb(1'b0, a, 4'h3, 16'h0000, q);
    chk(q, {16'h0000, e}, "register read");
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic reset_vals();
    rd(OFS_DIR, 16'h0000);
    rd(OFS_UPPER, 16'h3302);
    rd(OFS_LOWER, 16'hff95);
    chk(oe_n, 16'haf08, "reset drive");
  endtask

  task automatic reserved_bits();
    wr(OFS_UPPER, 16'h0000);
    rd(OFS_UPPER, 16'h0002);
    wr(OFS_LOWER, 16'h0000);
    rd(OFS_LOWER, 16'haa00);
    wr(4'hc, 16'hffff);
    rd(4'hc, 16'h0000);
    rd(OFS_DIR, 16'h0000);
  endtask

  task automatic byte_lanes();
    logic [31:0] q;
    wb(1'b1, OFS_UPPER, 4'h2, 16'hffff, q);
    wb(1'b1, OFS_UPPER, 4'h1, 16'h00c1, q);
    rd(OFS_UPPER, 16'hffc3);
  endtask

  task automatic direction();
    wr(OFS_UPPER, 16'h0002);
    wr(OFS_LOWER, 16'haa00);
    wr(OFS_DIR, 16'h0ff0);
    rd(OFS_DIR, 16'h0ff0);
    port_out <= 16'h5a3c;
    ext <= 16'hc3c3;
    repeat (6) @(posedge clk_i);
    chk(oe_n, 16'hf00f, "direction drive");
    chk(pin_o & 16'h0ff0, 16'h0a30, "port value");
    chk(port_data, 16'hca33, "port read");
  endtask

  // Every code but port of every pin, with peripheral outputs low and then high.
  task automatic fn_table();
    logic [47:0] e;
    logic [15:0] m;
    logic        v;
    logic        off;
    wr(OFS_DIR, 16'hffff);
    port_out <= 16'h0000;
    for (int p = 0; p < 2; p++) begin
      v = (p == 1);
      for (int i = 0; i < 38; i++) begin
        e = TAB[i];
        m = 16'h0001 << e[27:24];
        wr(OFS_UPPER, e[44] ? e[43:28] : 16'h0002);
        wr(OFS_LOWER, e[44] ? 16'haa00 : e[43:28]);
        lvl <= v;
        ext <= m;
        repeat (6) @(posedge clk_i);
        off = (e[23:20] == 4'h0) ? 1'b0 : (e[23:20] == 4'h3) ? ~v : 1'b1;
        chk(oe_n & m, off ? m : 16'h0, "pin drive");
        if (!off) begin
          chk(pin_o & m, v ? m : 16'h0, "pin value");
        end else begin
          chk(to_periph, e[16:0], "periph in");
        end
        chk(port_data, (off || v) ? m : 16'h0, "pin read");
      end
    end
    rd(OFS_LOWER, 16'haa03);
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = '0;
    wdat = '0;
    ext = '0;
    port_out = '0;
    lvl = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    do_reset();
    reset_vals();
    reserved_bits();
    byte_lanes();
    direction();
    fn_table();
    do_reset();
    reset_vals();
    end_sim();
  end
endmodule
